// ---- core/dtc_cfg.svh ----
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// Register offsets on the plain register port.
`define DTC_OFS_CTRL 3'h0
`define DTC_OFS_MODE 3'h1
`define DTC_OFS_T0_LO 3'h2
`define DTC_OFS_T1_LO 3'h3
`define DTC_OFS_T0_HI 3'h4
`define DTC_OFS_T1_HI 3'h5
// Control register bit positions.
`define DTC_B_T1_OVF 7
`define DTC_B_T1_RUN 6
`define DTC_B_T0_OVF 5
`define DTC_B_T0_RUN 4
`define DTC_B_X1_FLAG 3
`define DTC_B_X1_TYPE 2
`define DTC_B_X0_FLAG 1
`define DTC_B_X0_TYPE 0
// Mode register: timer 1 in the upper nibble, timer 0 in the lower.
`define DTC_B_GATE 3
`define DTC_B_CT 2
`define DTC_B_MODE_HI 1
`define DTC_B_MODE_LO 0
`define DTC_RST_BYTE 8'h00
`define DTC_RST_PIN 2'h3
`define DTC_PRESCALE 5'h1f
`endif

// ---- core/dtc_pkg.sv ----
package dtc_pkg;
   typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_MRL, DTC_M3} dtc_mode_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] t0_lo;
      logic [7:0] t0_hi;
      logic [7:0] t1_lo;
      logic [7:0] t1_hi;
      logic [4:0] pre0;
      logic [4:0] pre1;
      logic [1:0] ev_s1;
      logic [1:0] ev_s2;
      logic [1:0] ev_prev;
      logic [1:0] int_s1;
      logic [1:0] int_s2;
      logic [1:0] int_prev;
      logic [7:0] rdata;
   } dtc_state_t;
endpackage : dtc_pkg

// ---- core/dtc_timer.sv ----
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer
   import dtc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Pins: count inputs and external interrupt inputs.
   input wire logic [1:0] count_in,
   input wire logic [1:0] ext_irq_in_n,
   // Interrupt vector acknowledges, one cycle pulses.
   input wire logic ack_timer0,
   input wire logic ack_timer1,
   input wire logic ack_ext0,
   input wire logic ack_ext1,
   // Interrupt requests.
   output logic irq_timer0,
   output logic irq_timer1,
   output logic irq_ext0,
   output logic irq_ext1
);
   dtc_state_t s_q;
   dtc_state_t s_d;
   logic [1:0] ev_fall;
   logic [1:0] int_fall;
   logic [1:0] int_rise;
   logic [1:0] run;
   logic [1:0] cnt_en;
   logic [1:0] pre_tick;
   logic [1:0] ovf;
   logic hi0_ovf;
   logic [3:0] mode_t1;
   logic [3:0] mode_t0;
   logic [8:0] sum_lo0;
   logic [8:0] sum_lo1;
   logic [8:0] sum_hi0;
   logic [8:0] sum_hi1;
   logic [8:0] sum_split;

   assign mode_t1 = s_q.mode[7:4];
   assign mode_t0 = s_q.mode[3:0];
   assign ev_fall = s_q.ev_prev & ~s_q.ev_s2;
   assign int_fall = s_q.int_prev & ~s_q.int_s2;
   assign int_rise = ~s_q.int_prev & s_q.int_s2;
   assign run[0] = s_q.ctrl[`DTC_B_T0_RUN];
   assign run[1] = s_q.ctrl[`DTC_B_T1_RUN] & (mode_t1[1:0] != 2'(DTC_M3));
   // Gate reads the interrupt pin level, high meaning pin released.
   assign cnt_en[0] = run[0] & (~mode_t0[`DTC_B_GATE] | s_q.int_s2[0])
      & (mode_t0[`DTC_B_CT] ? ev_fall[0] : 1'b1);
   assign cnt_en[1] = run[1] & (~mode_t1[`DTC_B_GATE] | s_q.int_s2[1])
      & (mode_t1[`DTC_B_CT] ? ev_fall[1] : 1'b1);
   assign pre_tick[0] = cnt_en[0] & (s_q.pre0 == `DTC_PRESCALE);
   assign pre_tick[1] = cnt_en[1] & (s_q.pre1 == `DTC_PRESCALE);
   assign sum_lo0 = {1'b0, s_q.t0_lo} + 9'h001;
   assign sum_lo1 = {1'b0, s_q.t1_lo} + 9'h001;
   assign sum_hi0 = {1'b0, s_q.t0_hi} + 9'h001;
   assign sum_hi1 = {1'b0, s_q.t1_hi} + 9'h001;
   assign sum_split = sum_hi0;
   // Mode 3 of timer zero borrows timer one's run bit for its high byte.
   assign hi0_ovf = (mode_t0[1:0] == 2'(DTC_M3)) & s_q.ctrl[`DTC_B_T1_RUN] & sum_split[8];

   always_comb
   begin
      s_d = s_q;
      ovf = 2'b00;
      s_d.ev_s1 = count_in;
      s_d.ev_s2 = s_q.ev_s1;
      s_d.ev_prev = s_q.ev_s2;
      // The interrupt synchronisers carry the pin level, so one means released.
      s_d.int_s1 = ext_irq_in_n;
      s_d.int_s2 = s_q.int_s1;
      s_d.int_prev = s_q.int_s2;
      // Timer zero.
      unique case (dtc_mode_t'(mode_t0[1:0]))
         DTC_M13:
         begin
            if (cnt_en[0])
            begin
               s_d.pre0 = s_q.pre0 + 5'h01;
            end
            if (pre_tick[0])
            begin
               s_d.t0_lo = sum_lo0[7:0];
               ovf[0] = sum_lo0[8];
            end
         end
         DTC_M16:
         begin
            if (cnt_en[0])
            begin
               s_d.t0_lo = sum_lo0[7:0];
               if (sum_lo0[8])
               begin
                  s_d.t0_hi = sum_hi0[7:0];
                  ovf[0] = sum_hi0[8];
               end
            end
         end
         DTC_MRL:
         begin
            if (cnt_en[0])
            begin
               s_d.t0_lo = sum_lo0[8] ? s_q.t0_hi : sum_lo0[7:0];
               ovf[0] = sum_lo0[8];
            end
         end
         DTC_M3:
         begin
            if (cnt_en[0])
            begin
               s_d.t0_lo = sum_lo0[7:0];
               ovf[0] = sum_lo0[8];
            end
            if (s_q.ctrl[`DTC_B_T1_RUN])
            begin
               s_d.t0_hi = sum_split[7:0];
            end
         end
      endcase
      // Timer one.
      unique case (dtc_mode_t'(mode_t1[1:0]))
         DTC_M13:
         begin
            if (cnt_en[1])
            begin
               s_d.pre1 = s_q.pre1 + 5'h01;
            end
            if (pre_tick[1])
            begin
               s_d.t1_lo = sum_lo1[7:0];
               ovf[1] = sum_lo1[8];
            end
         end
         DTC_M16:
         begin
            if (cnt_en[1])
            begin
               s_d.t1_lo = sum_lo1[7:0];
               if (sum_lo1[8])
               begin
                  s_d.t1_hi = sum_hi1[7:0];
                  ovf[1] = sum_hi1[8];
               end
            end
         end
         DTC_MRL:
         begin
            if (cnt_en[1])
            begin
               s_d.t1_lo = sum_lo1[8] ? s_q.t1_hi : sum_lo1[7:0];
               ovf[1] = sum_lo1[8];
            end
         end
         DTC_M3:
         begin
            s_d.t1_lo = s_q.t1_lo;
         end
      endcase
      // Software writes take the register; hardware counting yields.
      if (reg_wr)
      begin
         unique case (reg_addr)
            `DTC_OFS_CTRL: s_d.ctrl = reg_wdata;
            `DTC_OFS_MODE: s_d.mode = reg_wdata;
            `DTC_OFS_T0_LO: s_d.t0_lo = reg_wdata;
            `DTC_OFS_T1_LO: s_d.t1_lo = reg_wdata;
            `DTC_OFS_T0_HI: s_d.t0_hi = reg_wdata;
            `DTC_OFS_T1_HI: s_d.t1_hi = reg_wdata;
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end
      // Acknowledges clear timer flags and edge-mode external flags, but a same-cycle set wins.
      if (ack_timer0)
      begin
         s_d.ctrl[`DTC_B_T0_OVF] = 1'b0;
      end
      if (ack_timer1)
      begin
         s_d.ctrl[`DTC_B_T1_OVF] = 1'b0;
      end
      if (ack_ext0 & s_d.ctrl[`DTC_B_X0_TYPE])
      begin
         s_d.ctrl[`DTC_B_X0_FLAG] = 1'b0;
      end
      if (ack_ext1 & s_d.ctrl[`DTC_B_X1_TYPE])
      begin
         s_d.ctrl[`DTC_B_X1_FLAG] = 1'b0;
      end
      if (ovf[0])
      begin
         s_d.ctrl[`DTC_B_T0_OVF] = 1'b1;
      end
      if (ovf[1] | hi0_ovf)
      begin
         s_d.ctrl[`DTC_B_T1_OVF] = 1'b1;
      end
      // Edge mode latches; level mode mirrors the low pin level.
      if (s_q.ctrl[`DTC_B_X0_TYPE])
      begin
         if (int_fall[0])
         begin
            s_d.ctrl[`DTC_B_X0_FLAG] = 1'b1;
         end
      end
      else
      begin
         s_d.ctrl[`DTC_B_X0_FLAG] = ~s_q.int_s2[0];
      end
      if (s_q.ctrl[`DTC_B_X1_TYPE])
      begin
         if (int_fall[1] | int_rise[1])
         begin
            s_d.ctrl[`DTC_B_X1_FLAG] = 1'b1;
         end
      end
      else
      begin
         s_d.ctrl[`DTC_B_X1_FLAG] = ~s_q.int_s2[1];
      end
      s_d.rdata = `DTC_RST_BYTE;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `DTC_OFS_CTRL: s_d.rdata = s_q.ctrl;
            `DTC_OFS_MODE: s_d.rdata = s_q.mode;
            `DTC_OFS_T0_LO: s_d.rdata = s_q.t0_lo;
            `DTC_OFS_T1_LO: s_d.rdata = s_q.t1_lo;
            `DTC_OFS_T0_HI: s_d.rdata = s_q.t0_hi;
            `DTC_OFS_T1_HI: s_d.rdata = s_q.t1_hi;
            default: s_d.rdata = `DTC_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
         // Synchronisers start at the released pin level, so no request or edge follows reset.
         s_q.ev_s1 <= `DTC_RST_PIN;
         s_q.ev_s2 <= `DTC_RST_PIN;
         s_q.ev_prev <= `DTC_RST_PIN;
         s_q.int_s1 <= `DTC_RST_PIN;
         s_q.int_s2 <= `DTC_RST_PIN;
         s_q.int_prev <= `DTC_RST_PIN;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign irq_timer0 = s_q.ctrl[`DTC_B_T0_OVF];
   assign irq_timer1 = s_q.ctrl[`DTC_B_T1_OVF];
   assign irq_ext0 = s_q.ctrl[`DTC_B_X0_FLAG];
   assign irq_ext1 = s_q.ctrl[`DTC_B_X1_FLAG];

   chk_t0_run_halt: assert property (@(posedge sys_clk) disable iff (rst)
      (!s_q.ctrl[`DTC_B_T0_RUN] && !reg_wr && mode_t0[1:0] == 2'(DTC_M16))
      |=> $stable(s_q.t0_lo))
      else $error("timer zero moved while halted");
   chk_t1_stop_mode: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t1[1:0] == 2'(DTC_M3) && !reg_wr) |=> $stable(s_q.t1_lo) && $stable(s_q.t1_hi))
      else $error("timer one moved in stopped mode");
   chk_t1_run_halt: assert property (@(posedge sys_clk) disable iff (rst)
      (!s_q.ctrl[`DTC_B_T1_RUN] && !reg_wr) |=> $stable(s_q.t1_lo))
      else $error("timer one moved while halted");
   chk_t1_reload: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t1[1:0] == 2'(DTC_MRL) && cnt_en[1] && s_q.t1_lo == 8'hff && !reg_wr)
      |=> s_q.t1_lo == $past(s_q.t1_hi) && s_q.ctrl[`DTC_B_T1_OVF])
      else $error("timer one reload failed");
   chk_t0_reload: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t0[1:0] == 2'(DTC_MRL) && cnt_en[0] && s_q.t0_lo == 8'hff && !reg_wr)
      |=> s_q.t0_lo == $past(s_q.t0_hi) && s_q.ctrl[`DTC_B_T0_OVF])
      else $error("timer zero reload failed");
   chk_t0_ovf_flag: assert property (@(posedge sys_clk) disable iff (rst)
      ovf[0] |=> s_q.ctrl[`DTC_B_T0_OVF])
      else $error("timer zero flag not set");
   chk_t1_ovf_flag: assert property (@(posedge sys_clk) disable iff (rst)
      (ovf[1] || hi0_ovf) |=> s_q.ctrl[`DTC_B_T1_OVF])
      else $error("timer one flag not set");
   chk_t1_ack_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (ack_timer1 && !ovf[1] && !hi0_ovf && !reg_wr) |=> !s_q.ctrl[`DTC_B_T1_OVF])
      else $error("timer one flag not cleared");
   chk_t0_gate: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t0[`DTC_B_GATE] && !s_q.int_s2[0] && !reg_wr && mode_t0[1:0] == 2'(DTC_M16))
      |=> $stable(s_q.t0_lo))
      else $error("gated timer zero counted");
   chk_t0_split_high: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t0[1:0] == 2'(DTC_M3) && s_q.ctrl[`DTC_B_T1_RUN] && !reg_wr)
      |=> s_q.t0_hi == 8'($past(s_q.t0_hi) + 8'h01))
      else $error("split high byte did not step");
   chk_t1_count_edge: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t1[`DTC_B_CT] && !ev_fall[1] && mode_t1[1:0] == 2'(DTC_M16) && !reg_wr)
      |=> $stable(s_q.t1_lo))
      else $error("timer one counted without an edge");
   chk_ext1_edge: assert property (@(posedge sys_clk) disable iff (rst)
      (s_q.ctrl[`DTC_B_X1_TYPE] && (int_rise[1] || int_fall[1]))
      |=> s_q.ctrl[`DTC_B_X1_FLAG])
      else $error("ext one edge missed");
   chk_ext0_edge: assert property (@(posedge sys_clk) disable iff (rst)
      (s_q.ctrl[`DTC_B_X0_TYPE] && int_fall[0]) |=> s_q.ctrl[`DTC_B_X0_FLAG])
      else $error("ext zero edge missed");
   chk_ext0_level: assert property (@(posedge sys_clk) disable iff (rst)
      (!s_q.ctrl[`DTC_B_X0_TYPE] && !reg_wr) |=> irq_ext0 == !$past(s_q.int_s2[0]))
      else $error("ext zero level request wrong");
   chk_t1_prescale: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_t1[1:0] == 2'(DTC_M13) && cnt_en[1] && s_q.pre1 != `DTC_PRESCALE && !reg_wr)
      |=> $stable(s_q.t1_lo))
      else $error("timer one prescaler skipped");
   chk_t0_lo_read: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_rd && reg_addr == `DTC_OFS_T0_LO) |=> reg_rdata == $past(s_q.t0_lo))
      else $error("timer zero low byte read wrong");
endmodule : dtc_timer

// ---- tb/dtc_core_model.sv ----
`timescale 1ns/1ps
module dtc_core_model
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst,
   // Requests and the lines on which vectoring is allowed.
   input wire logic [3:0] ack_en,
   input wire logic [3:0] irq,
   // Vector acknowledge pulses.
   output logic [3:0] ack
);
   // A request is vectored one cycle after it is seen; masking with the last ack keeps a stale request from being acked twice.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         ack <= 4'h0;
      else
         ack <= ack_en & irq & ~ack;
   end
endmodule : dtc_core_model

// ---- tb/test_dtc_timer.sv ----
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module test_dtc_timer;
   import dtc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] count_in = 2'h3;
   logic [1:0] ext_irq_in_n = 2'h3;
   logic [3:0] ack_en = 4'h0;
   logic [3:0] ack;
   logic [3:0] irq;
   logic [7:0] irq_at;
   logic [7:0] v;
   logic [7:0] h;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   always #20 sys_clk = ~sys_clk;
   dtc_timer u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_in(count_in),
      .ext_irq_in_n(ext_irq_in_n), .ack_timer0(ack[0]), .ack_timer1(ack[1]),
      .ack_ext0(ack[2]), .ack_ext1(ack[3]), .irq_timer0(irq[0]), .irq_timer1(irq[1]),
      .irq_ext0(irq[2]), .irq_ext1(irq[3]));
   dtc_core_model u_core (.sys_clk(sys_clk), .rst(rst), .ack_en(ack_en), .irq(irq), .ack(ack));
   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // Gives m+1 counting edges; the requests are noted after m-1 of them.
   task automatic run(input logic [7:0] on, input int m);
      wr(`DTC_OFS_CTRL, on);
      repeat (m - 1) @(posedge sys_clk);
      #1;
      irq_at = {4'h0, irq};
      wr(`DTC_OFS_CTRL, 8'h00);
   endtask : run
   task automatic pin(input logic [1:0] p, input logic [7:0] e);
      @(posedge sys_clk);
      ext_irq_in_n <= p;
      repeat (6) @(posedge sys_clk);
      #1;
      check({4'h0, irq}, e);
   endtask : pin
   task automatic ackall();
      @(posedge sys_clk);
      ack_en <= 4'hf;
      repeat (6) @(posedge sys_clk);
      ack_en <= 4'h0;
      #1;
      check({4'h0, irq}, 8'h00);
   endtask : ackall
   function automatic logic [7:0] reload(input logic [7:0] lo, input logic [7:0] hi, input int k);
      for (int i = 0; i < k; i++)
         lo = (lo == 8'hff) ? hi : lo + 8'h01;
      return lo;
   endfunction : reload
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         results();
      end
   end
   initial
   begin
      void'($urandom(32'h21ce));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), v);
         check(v, `DTC_RST_BYTE);
      end
      for (int a = 1; a < 6; a++)
      begin
         h = 8'($urandom);
         wr(3'(a), h);
         wr(3'h6, ~h);
         rd(3'(a), v);
         check(v, h);
      end
      rd(3'h6, v);
      check(v, 8'h00);
      // Timer one behind the prescaler steps twice in 64 cycles and wraps.
      wr(`DTC_OFS_MODE, 8'h00);
      wr(`DTC_OFS_T1_LO, 8'hff);
      run(8'h40, 63);
      check(irq_at, 8'h02);
      rd(`DTC_OFS_T1_LO, v);
      check(v, 8'h01);
      wr(`DTC_OFS_MODE, 8'h01);
      wr(`DTC_OFS_T0_LO, 8'hf0);
      wr(`DTC_OFS_T0_HI, 8'hff);
      run(8'h10, 31);
      check(irq_at, 8'h01);
      rd(`DTC_OFS_T0_LO, v);
      check(v, 8'h10);
      rd(`DTC_OFS_T0_HI, v);
      check(v, 8'h00);
      h = 8'($urandom_range(253, 0));
      n = $urandom_range(40, 2);
      wr(`DTC_OFS_MODE, 8'h22);
      wr(`DTC_OFS_T1_HI, h);
      wr(`DTC_OFS_T1_LO, 8'hfe);
      wr(`DTC_OFS_T0_HI, h);
      wr(`DTC_OFS_T0_LO, 8'hfe);
      run(8'h50, n - 1);
      rd(`DTC_OFS_T1_LO, v);
      check(v, reload(8'hfe, h, n));
      rd(`DTC_OFS_T0_LO, v);
      check(v, reload(8'hfe, h, n));
      rd(`DTC_OFS_T1_HI, v);
      check(v, h);
      // Timer one stays still while the split timer zero high byte runs on its run bit.
      wr(`DTC_OFS_MODE, 8'h33);
      wr(`DTC_OFS_T0_HI, 8'hfc);
      run(8'h40, 7);
      check(irq_at, 8'h02);
      rd(`DTC_OFS_T0_HI, v);
      check(v, 8'h04);
      rd(`DTC_OFS_T1_LO, v);
      check(v, reload(8'hfe, h, n));
      // Both 16-bit timers overflow two edges after start; the core's vector clears them.
      wr(`DTC_OFS_MODE, 8'h11);
      wr(`DTC_OFS_T0_HI, 8'hff);
      wr(`DTC_OFS_T1_HI, 8'hff);
      wr(`DTC_OFS_T0_LO, 8'hfe);
      wr(`DTC_OFS_T1_LO, 8'hfe);
      wr(`DTC_OFS_CTRL, 8'h50);
      repeat (4) @(posedge sys_clk);
      #1;
      check({4'h0, irq}, 8'h03);
      ackall();
      wr(`DTC_OFS_CTRL, 8'h00);
      wr(`DTC_OFS_MODE, 8'h09);
      wr(`DTC_OFS_T0_LO, 8'h00);
      ext_irq_in_n <= 2'b10;
      run(8'h10, 20);
      check(irq_at, 8'h04);
      rd(`DTC_OFS_T0_LO, v);
      check(v, 8'h00);
      ext_irq_in_n <= 2'b11;
      run(8'h10, 20);
      check(irq_at, 8'h00);
      rd(`DTC_OFS_T0_LO, v);
      check({7'h00, v != 8'h00}, 8'h01);
      // Timer one counts falling edges of its count pin only.
      n = $urandom_range(10, 1);
      wr(`DTC_OFS_MODE, 8'h50);
      wr(`DTC_OFS_T1_LO, 8'h00);
      wr(`DTC_OFS_CTRL, 8'h40);
      for (int k = 0; k < n; k++)
      begin
         count_in <= 2'b01;
         repeat (4) @(posedge sys_clk);
         count_in <= 2'b11;
         repeat (4) @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
      wr(`DTC_OFS_CTRL, 8'h00);
      rd(`DTC_OFS_T1_LO, v);
      check(v, 8'(n));
      wr(`DTC_OFS_CTRL, 8'h05);
      pin(2'b10, 8'h04);
      pin(2'b11, 8'h04);
      ackall();
      pin(2'b01, 8'h08);
      ackall();
      pin(2'b11, 8'h08);
      ackall();
      results();
   end
endmodule : test_dtc_timer
